// ==== core/cll_logic_block.sv ====
/*
 * Configurable logic function block: OR, NOR, latch or set/reset storage,
 * selected and observed over an AXI4-Lite slave.
 * Assumes one clock, asynchronous active-low reset, and upstream blocks on the same clock.
 */
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// - OR: output true when any connected input true, false when all false.
// - NOR: output true only when every connected input is false.
// - Gate functions consider connected inputs only; unconnected ones are ignored.
// - A function selection setting picks the behaviour, NOR reporting all-false.
// - Undetermined result takes value and error from a four-way handling choice.
// - Latch: while hold is false the source passes straight to the output.
// - Latch: hold rising captures the source and keeps it until hold falls.
// - Storage: a true set drives output true unless reset is true.
// - Storage: reset forces output false and overrides set.
// - Storage: set rising during reset keeps output false until reset falls.
// - Storage: set is ignored when the output is already true.
// - Storage: output retains its state between set and reset events.
// - Latch: faulty or false hold passes source value and error through.
// - Storage: faulty set while true keeps output true, no error.
// - Gates ignore input errors when valid inputs settle the output.
module cll_logic_block #(
	parameter int NUM_INPUTS = cll_pkg::CLL_NUM_INPUTS
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sync_clear,
	input wire cll_pkg::cll_sig_t [NUM_INPUTS-1:0] sig_in,
	output cll_pkg::cll_sig_t sig_out,
	input wire logic [cll_pkg::CLL_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cll_pkg::CLL_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cll_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	cll_func_t func;
	cll_err_mode_t err_mode;
	cll_sig_t gate_result;
	cll_sig_t next_latch;
	cll_sig_t next_out;
	logic gate_undetermined;
	logic undetermined;
	logic next_stored;
	logic stored;
	logic holding;

	logic aw_fire;
	logic w_fire;
	logic b_fire;
	logic ar_fire;
	logic r_fire;
	logic aw_held;
	logic w_held;
	logic got_aw;
	logic got_w;
	logic do_write;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;
	logic [CLL_ADDR_W-1:0] aw_addr;
	logic [CLL_ADDR_W-1:0] write_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] write_data;
	logic [3:0] write_strb;
	logic [31:0] read_word;
	logic read_hit;
	logic write_hit;
	logic write_known;
	logic ctrl_write;
	logic [31:0] status_word;
	logic [31:0] inputs_word;

	// ----------------------------------------
	// Function units
	// ----------------------------------------
	cll_gate_eval #(
		.NUM_INPUTS(NUM_INPUTS)
	) u_gate (
		.sig_in(sig_in),
		.func(func),
		.err_mode(err_mode),
		.result(gate_result),
		.undetermined(gate_undetermined)
	);

	cll_storage u_storage (
		.clock(clock),
		.resetn(resetn),
		.sync_clear(sync_clear),
		.source(sig_in[CLL_IN_SOURCE]),
		.hold(sig_in[CLL_IN_HOLD]),
		.set_in(sig_in[CLL_IN_SET]),
		.reset_in(sig_in[CLL_IN_RESET]),
		.next_latch(next_latch),
		.next_stored(next_stored),
		.stored(stored),
		.holding(holding)
	);

	// ----------------------------------------
	// Output selection
	// ----------------------------------------
	always_comb begin
		next_out = '0;
		next_out.connected = 1'b1;
		undetermined = 1'b0;
		case (func)
			CLL_FN_OR, CLL_FN_NOR: begin
				next_out = gate_result;
				undetermined = gate_undetermined;
			end
			CLL_FN_LATCH: begin
				next_out.value = next_latch.value;
				next_out.error = next_latch.error;
			end
			CLL_FN_SET_RESET: begin
				next_out.value = next_stored;
				next_out.error = 1'b0;
			end
			default: begin
				next_out.value = 1'b0;
			end
		endcase
	end

	// Result is registered so downstream blocks see one value per cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sig_out <= '0;
		end else if (sync_clear) begin
			sig_out <= '0;
		end else begin
			sig_out <= next_out;
		end
	end

	// ----------------------------------------
	// Write channel handshake
	// ----------------------------------------
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign b_fire = s_axi_bvalid & s_axi_bready;

	always_comb begin
		got_aw = aw_held | aw_fire;
		got_w = w_held | w_fire;
		// Address and data may arrive in either order
		do_write = got_aw & got_w & ~s_axi_bvalid;
		next_aw_held = got_aw & ~do_write;
		next_w_held = got_w & ~do_write;
		next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
		write_addr = aw_fire ? s_axi_awaddr : aw_addr;
		write_data = w_fire ? s_axi_wdata : w_data;
		write_strb = w_fire ? s_axi_wstrb : w_strb;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
		end else begin
			s_axi_bvalid <= next_bvalid;
		end
	end

	// Ready drops while a channel is parked or a response is pending
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~next_aw_held & ~next_bvalid;
			s_axi_wready <= ~next_w_held & ~next_bvalid;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (aw_fire) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Only the control word is writable; status and input words are read-only
	assign write_hit = (write_addr == CLL_REG_CONTROL);
	assign ctrl_write = do_write & write_hit & write_strb[0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			func <= cll_func_t'(CLL_FUNC_RESET);
			err_mode <= cll_err_mode_t'(CLL_EH_RESET);
		end else if (ctrl_write) begin
			func <= cll_func_t'(write_data[CLL_CTRL_FUNC_LSB +: 2]);
			err_mode <= cll_err_mode_t'(write_data[CLL_CTRL_EH_LSB +: 2]);
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	// Unmapped writes still complete, but answer with a slave error
	always_comb begin
		write_known = 1'b0;
		case (write_addr)
			CLL_REG_CONTROL, CLL_REG_STATUS, CLL_REG_INPUTS: begin
				write_known = 1'b1;
			end
			default: begin
				write_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_bresp <= CLL_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bresp <= write_known ? CLL_RESP_OKAY : CLL_RESP_SLVERR;
		end
	end

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	always_comb begin
		status_word = '0;
		status_word[CLL_STAT_VALUE] = sig_out.value;
		status_word[CLL_STAT_ERROR] = sig_out.error;
		status_word[CLL_STAT_STORED] = stored;
		status_word[CLL_STAT_HOLDING] = holding;
		status_word[CLL_STAT_UNDETERMINED] = undetermined;
	end

	// Snapshot of the live inputs; only the first eight fit the word
	localparam int IN_FIELD_W = CLL_IN_ERROR_LSB - CLL_IN_VALUE_LSB;
	for (genvar i = 0; i < IN_FIELD_W; i++) begin : g_inputs
		if (i < NUM_INPUTS) begin : g_used
			assign inputs_word[CLL_IN_VALUE_LSB + i] = sig_in[i].value;
			assign inputs_word[CLL_IN_ERROR_LSB + i] = sig_in[i].error;
			assign inputs_word[CLL_IN_CONN_LSB + i] = sig_in[i].connected;
		end else begin : g_unused
			assign inputs_word[CLL_IN_VALUE_LSB + i] = 1'b0;
			assign inputs_word[CLL_IN_ERROR_LSB + i] = 1'b0;
			assign inputs_word[CLL_IN_CONN_LSB + i] = 1'b0;
		end
	end
	assign inputs_word[31:24] = '0;

	always_comb begin
		read_hit = 1'b1;
		read_word = '0;
		case (s_axi_araddr)
			CLL_REG_CONTROL: begin
				read_word[CLL_CTRL_FUNC_LSB +: 2] = func;
				read_word[CLL_CTRL_EH_LSB +: 2] = err_mode;
			end
			CLL_REG_STATUS: begin
				read_word = status_word;
			end
			CLL_REG_INPUTS: begin
				read_word = inputs_word;
			end
			default: begin
				read_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign r_fire = s_axi_rvalid & s_axi_rready;
	assign next_rvalid = ar_fire | (s_axi_rvalid & ~r_fire);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_rvalid <= next_rvalid;
		end
	end

	// Address refused while a read answer stands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= ~next_rvalid;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= CLL_RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_hit ? CLL_RESP_OKAY : CLL_RESP_SLVERR;
		end
	end

endmodule

// ==== core/cll_pkg.sv ====
/*
 * Shared types and constants for the configurable logic and latch block.
 * Assumes a single clock domain and AXI4-Lite register access with 32-bit data.
 */
package cll_pkg;

	// ----------------------------------------
	// Signal carrier
	// ----------------------------------------
	typedef struct packed {
		logic connected;
		logic error;
		logic value;
	} cll_sig_t;

	// ----------------------------------------
	// Function and error handling selections
	// ----------------------------------------
	typedef enum logic [1:0] {
		CLL_FN_OR = 2'h0,
		CLL_FN_NOR = 2'h1,
		CLL_FN_LATCH = 2'h2,
		CLL_FN_SET_RESET = 2'h3
	} cll_func_t;

	typedef enum logic [1:0] {
		CLL_EH_TRUE_GOOD = 2'h0,
		CLL_EH_TRUE_BAD = 2'h1,
		CLL_EH_FALSE_GOOD = 2'h2,
		CLL_EH_FALSE_BAD = 2'h3
	} cll_err_mode_t;

	// Error mode encoding: bit 1 set means false, bit 0 set means error
	localparam int CLL_EH_FALSE_BIT = 1;
	localparam int CLL_EH_BAD_BIT = 0;

	// ----------------------------------------
	// Input roles for the storage functions
	// ----------------------------------------
	localparam int CLL_IN_SOURCE = 0;
	localparam int CLL_IN_HOLD = 1;
	localparam int CLL_IN_SET = 0;
	localparam int CLL_IN_RESET = 1;
	localparam int CLL_NUM_INPUTS = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int CLL_ADDR_W = 4;
	localparam logic [CLL_ADDR_W-1:0] CLL_REG_CONTROL = 4'h0;
	localparam logic [CLL_ADDR_W-1:0] CLL_REG_STATUS = 4'h4;
	localparam logic [CLL_ADDR_W-1:0] CLL_REG_INPUTS = 4'h8;

	localparam int CLL_CTRL_FUNC_LSB = 0;
	localparam int CLL_CTRL_EH_LSB = 2;
	localparam logic [1:0] CLL_FUNC_RESET = 2'h0;
	localparam logic [1:0] CLL_EH_RESET = 2'h2;

	localparam int CLL_STAT_VALUE = 0;
	localparam int CLL_STAT_ERROR = 1;
	localparam int CLL_STAT_STORED = 2;
	localparam int CLL_STAT_HOLDING = 3;
	localparam int CLL_STAT_UNDETERMINED = 4;

	localparam int CLL_IN_VALUE_LSB = 0;
	localparam int CLL_IN_ERROR_LSB = 8;
	localparam int CLL_IN_CONN_LSB = 16;

	localparam logic [1:0] CLL_RESP_OKAY = 2'h0;
	localparam logic [1:0] CLL_RESP_SLVERR = 2'h2;

endpackage

// ==== core/cll_gate_eval.sv ====
/*
 * Combinational OR / NOR evaluation over connected inputs with error resolution.
 * Assumes inputs come from logic on the same clock; the caller registers the result.
 */
`timescale 1ns/10ps
module cll_gate_eval #(
	parameter int NUM_INPUTS = 8
) (
	input wire cll_pkg::cll_sig_t [NUM_INPUTS-1:0] sig_in,
	input wire cll_pkg::cll_func_t func,
	input wire cll_pkg::cll_err_mode_t err_mode,
	output cll_pkg::cll_sig_t result,
	output logic undetermined
);
	import cll_pkg::*;

	logic [NUM_INPUTS-1:0] good_true;
	logic [NUM_INPUTS-1:0] bad_input;
	logic any_true;
	logic any_bad;

	// ----------------------------------------
	// Per-input qualification
	// ----------------------------------------
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_qual
		assign good_true[i] = sig_in[i].connected & ~sig_in[i].error & sig_in[i].value;
		assign bad_input[i] = sig_in[i].connected & sig_in[i].error;
	end

	assign any_true = |good_true;
	assign any_bad = |bad_input;

	// ----------------------------------------
	// Result
	// ----------------------------------------
	// One good true input settles both functions; errors only matter otherwise
	assign undetermined = ~any_true & any_bad;

	always_comb begin
		result.connected = 1'b1;
		if (undetermined) begin
			result.value = ~err_mode[CLL_EH_FALSE_BIT];
			result.error = err_mode[CLL_EH_BAD_BIT];
		end else if (func == CLL_FN_NOR) begin
			result.value = ~any_true;
			result.error = 1'b0;
		end else begin
			result.value = any_true;
			result.error = 1'b0;
		end
	end

endmodule

// ==== core/cll_storage.sv ====
/*
 * Latch and set/reset storage state for the logic block.
 * Assumes source, hold, set and reset arrive on the same clock; next values feed the output register.
 */
`timescale 1ns/10ps
module cll_storage (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sync_clear,
	input wire cll_pkg::cll_sig_t source,
	input wire cll_pkg::cll_sig_t hold,
	input wire cll_pkg::cll_sig_t set_in,
	input wire cll_pkg::cll_sig_t reset_in,
	output cll_pkg::cll_sig_t next_latch,
	output logic next_stored,
	output logic stored,
	output logic holding
);
	import cll_pkg::*;

	cll_sig_t latch;
	logic hold_active;
	logic set_good;
	logic reset_good;

	// ----------------------------------------
	// Latch
	// ----------------------------------------
	// A faulty hold cannot be trusted, so the source passes through
	assign hold_active = hold.connected & hold.value & ~hold.error;
	// Capture in the sample where hold first reads true, keep while it stays
	assign next_latch = (hold_active && holding) ? latch : source;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			latch <= '0;
			holding <= 1'b0;
		end else if (sync_clear) begin
			latch <= '0;
			holding <= 1'b0;
		end else begin
			latch <= next_latch;
			holding <= hold_active;
		end
	end

	// ----------------------------------------
	// Set/reset storage
	// ----------------------------------------
	// Faulty set or reset inputs are ignored; the stored state carries no error
	assign set_good = set_in.connected & set_in.value & ~set_in.error;
	assign reset_good = reset_in.connected & reset_in.value & ~reset_in.error;
	// Reset dominates; set while already true changes nothing
	assign next_stored = reset_good ? 1'b0 : (set_good ? 1'b1 : stored);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stored <= 1'b0;
		end else if (sync_clear) begin
			stored <= 1'b0;
		end else begin
			stored <= next_stored;
		end
	end

endmodule

// ==== verification/cll_logic_block_monitor.sv ====
/*
 * Port checker for the logic block.
 * Assumes control writes offer address and data on the same edge.
 */
`timescale 1ns/10ps
module cll_logic_block_monitor #(
	parameter int NUM_INPUTS = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sync_clear,
	input wire cll_pkg::cll_sig_t [NUM_INPUTS-1:0] sig_in,
	input wire cll_pkg::cll_sig_t sig_out,
	input wire logic [cll_pkg::CLL_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready
);
	import cll_pkg::*;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	cll_func_t fn;
	cll_func_t fn_prev;
	cll_err_mode_t eh;
	logic [NUM_INPUTS-1:0] good;
	logic [NUM_INPUTS-1:0] cerr;
	logic any_t;
	logic undet;
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			good[i] = sig_in[i].connected && !sig_in[i].error && sig_in[i].value;
			cerr[i] = sig_in[i].connected && sig_in[i].error;
		end
	end
	assign any_t = |good;
	assign undet = !any_t && |cerr;
	// Mirror of the control register, same edge as the slave
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fn <= cll_func_t'(CLL_FUNC_RESET);
			fn_prev <= cll_func_t'(CLL_FUNC_RESET);
			eh <= cll_err_mode_t'(CLL_EH_RESET);
		end else begin
			fn_prev <= fn;
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
				&& s_axi_awaddr == CLL_REG_CONTROL && s_axi_wstrb[0]) begin
				fn <= cll_func_t'(s_axi_wdata[1:0]);
				eh <= cll_err_mode_t'(s_axi_wdata[3:2]);
			end
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_or_true: assert property (fn == CLL_FN_OR && any_t && !sync_clear
		|=> sig_out.value && !sig_out.error) else $error("or output not true");
	chk_or_false: assert property (fn == CLL_FN_OR && !any_t && !(|cerr) && !sync_clear
		|=> !sig_out.value && !sig_out.error) else $error("or output not false");
	chk_nor_out: assert property (fn == CLL_FN_NOR && !undet && !sync_clear
		|=> sig_out.value == !$past(any_t) && !sig_out.error) else $error("nor output wrong");
	chk_undet_choice: assert property (fn inside {CLL_FN_OR, CLL_FN_NOR} && undet && !sync_clear
		|=> sig_out.value == !$past(eh[CLL_EH_FALSE_BIT]) && sig_out.error == $past(eh[CLL_EH_BAD_BIT]))
		else $error("error handling choice ignored");
	chk_latch_pass: assert property (fn == CLL_FN_LATCH && !good[CLL_IN_HOLD]
		&& sig_in[CLL_IN_SOURCE].connected && !sync_clear
		|=> sig_out.value == $past(sig_in[CLL_IN_SOURCE].value)
		&& sig_out.error == $past(sig_in[CLL_IN_SOURCE].error)) else $error("latch not transparent");
	chk_latch_keep: assert property (fn == CLL_FN_LATCH && good[CLL_IN_HOLD] && !sync_clear
		##1 fn == CLL_FN_LATCH && good[CLL_IN_HOLD] && !sync_clear |=> $stable(sig_out))
		else $error("latched output moved");
	chk_sr_reset: assert property (fn == CLL_FN_SET_RESET && good[CLL_IN_RESET]
		|=> !sig_out.value && !sig_out.error) else $error("reset did not win");
	chk_sr_set: assert property (fn == CLL_FN_SET_RESET && good[CLL_IN_SET]
		&& !good[CLL_IN_RESET] && !sync_clear |=> sig_out.value && !sig_out.error) else $error("set failed");
	chk_sr_retain: assert property (fn == CLL_FN_SET_RESET && fn_prev == CLL_FN_SET_RESET
		&& !good[CLL_IN_SET] && !good[CLL_IN_RESET] && !sync_clear
		|=> $stable(sig_out.value) && !sig_out.error) else $error("stored state lost");
	chk_clear_out: assert property (sync_clear |=> sig_out == '0) else $error("clear ignored");
	chk_connected: assert property (!sync_clear |=> sig_out.connected) else $error("output not connected");
endmodule
bind cll_logic_block cll_logic_block_monitor #(.NUM_INPUTS(NUM_INPUTS)) u_cll_logic_block_monitor (
	.clock(clock),
	.resetn(resetn),
	.sync_clear(sync_clear),
	.sig_in(sig_in),
	.sig_out(sig_out),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready)
);

// ==== verification/cll_src_model.sv ====
/*
 * Upstream blocks feeding the logic block, one register stage.
 * Assumes the bench sets the wanted pattern once per cycle.
 */
`timescale 1ns/10ps
module cll_src_model #(
	parameter int N = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire cll_pkg::cll_sig_t [N-1:0] want,
	input wire logic want_clr,
	output cll_pkg::cll_sig_t [N-1:0] sig,
	output logic clr
);
	import cll_pkg::*;
	// Unconnected links carry junk that flips every cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sig <= '0;
			clr <= 1'b0;
		end else begin
			clr <= want_clr;
			for (int i = 0; i < N; i++) begin
				sig[i] <= want[i].connected ? want[i] : {1'b0, ~sig[i].error, ~sig[i].value};
			end
		end
	end
endmodule

// ==== verification/test_cll_logic_block.sv ====
/*
 * Self-checking bench for the logic block.
 * Assumes the checker is bound to the design and sources sit in the model.
 */
`timescale 1ns/10ps
module test_cll_logic_block;
	import cll_pkg::*;
	localparam int N = CLL_NUM_INPUTS;
	logic clock = 1'b0, resetn = 1'b0, want_clr = 1'b0, clr, chk_en = 1'b0;
	cll_sig_t [N-1:0] want = '0;
	cll_sig_t [N-1:0] sig;
	cll_sig_t sig_out, exp_out;
	logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	cll_func_t cur_fn = CLL_FN_OR;
	cll_err_mode_t cur_eh = CLL_EH_FALSE_GOOD;
	logic lv, le, held, sr, und;
	always #2.5 clock = ~clock;
	cll_src_model #(.N(N)) u_cll_src_model (.clock(clock), .resetn(resetn), .want(want),
		.want_clr(want_clr), .sig(sig), .clr(clr));
	cll_logic_block #(.NUM_INPUTS(N)) u_cll_logic_block (.clock(clock), .resetn(resetn),
		.sync_clear(clr), .sig_in(sig), .sig_out(sig_out), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// ----------------------------------------
	// Reference
	// ----------------------------------------
	function automatic logic good(cll_sig_t s);
		return s.connected && !s.error && s.value;
	endfunction
	function automatic logic [31:0] in_word(cll_sig_t [N-1:0] s);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < N; i++) begin
			if (s[i].connected) begin
				w[CLL_IN_VALUE_LSB + i] = s[i].value;
				w[CLL_IN_ERROR_LSB + i] = s[i].error;
				w[CLL_IN_CONN_LSB + i] = 1'b1;
			end
		end
		return w;
	endfunction
	always @(posedge clock) begin
		logic anyt, cerr, hg, v, e;
		anyt = 1'b0;
		cerr = 1'b0;
		for (int i = 0; i < N; i++) begin
			anyt |= good(sig[i]);
			cerr |= sig[i].connected & sig[i].error;
		end
		hg = good(sig[CLL_IN_HOLD]);
		und = (cur_fn inside {CLL_FN_OR, CLL_FN_NOR}) && !anyt && cerr;
		if (!resetn || clr) begin
			exp_out = '0;
			{lv, le, sr} = 3'h0;
		end else begin
			if (hg && !held) {lv, le} = {sig[CLL_IN_SOURCE].value, sig[CLL_IN_SOURCE].error};
			if (good(sig[CLL_IN_RESET])) sr = 1'b0;
			else if (good(sig[CLL_IN_SET])) sr = 1'b1;
			case (cur_fn)
				CLL_FN_OR, CLL_FN_NOR: begin
					{v, e} = {anyt ^ (cur_fn == CLL_FN_NOR), 1'b0};
					if (!anyt && cerr) {v, e} = {!cur_eh[1], cur_eh[0]};
				end
				CLL_FN_LATCH: {v, e} = hg ? {lv, le} : {sig[CLL_IN_SOURCE].value, sig[CLL_IN_SOURCE].error};
				default: {v, e} = {sr, 1'b0};
			endcase
			exp_out = {1'b1, e, v};
		end
		held = hg && resetn && !clr;
	end
	always @(negedge clock) if (chk_en) check(32'(sig_out), 32'(exp_out));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] ex);
		samples_checked++;
		if (seen !== ex) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, ex);
		end
	endtask
	task automatic summarize;
		if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge clock);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cll_sig_t [N-1:0] p;
		logic [31:0] d;
		logic [1:0] r;
		logic c;
		int n;
		void'($urandom(32'h1140));
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rd(CLL_REG_CONTROL, d, r);
		check(d, {28'h0, CLL_EH_RESET, CLL_FUNC_RESET});
		rd(4'hC, d, r);
		check({d[29:0], r}, {30'h0, CLL_RESP_SLVERR});
		wr(4'hC, 32'h3, 4'hF, CLL_RESP_SLVERR);
		wr(CLL_REG_STATUS, 32'h3, 4'hF, CLL_RESP_OKAY);
		wr(CLL_REG_CONTROL, 32'h3, 4'h0, CLL_RESP_OKAY);
		rd(CLL_REG_CONTROL, d, r);
		check(d, {28'h0, CLL_EH_RESET, CLL_FUNC_RESET});
		for (int k = 0; k < 16; k++) begin
			{cur_eh, cur_fn} = {cll_err_mode_t'(k[3:2]), cll_func_t'(k[1:0])};
			wr(CLL_REG_CONTROL, 32'(k), 4'h1, CLL_RESP_OKAY);
			rd(CLL_REG_CONTROL, d, r);
			check(d, 32'(k));
			chk_en = 1'b1;
			repeat (60) begin
				@(posedge clock);
				// Storage modes need inputs that stay put for a while
				if (!k[1] || $urandom_range(3) == 0) begin
					c = $urandom_range(15) == 0;
					n = $urandom_range(N);
					for (int i = 0; i < N; i++) p[i] = {i < n, $urandom_range(5) == 0, 1'($urandom)};
					if (c) p[CLL_IN_HOLD].value = 1'b0;
					if (k[1:0] == 2'h2) p[CLL_IN_SOURCE].connected = 1'b1;
					want <= p;
					want_clr <= c;
				end
			end
			// Let the last pattern reach the output before the snapshot
			repeat (3) @(posedge clock);
			chk_en = 1'b0;
			rd(CLL_REG_STATUS, d, r);
			check(32'(d[4:0]), 32'({und, held, sr, exp_out.error, exp_out.value}));
			rd(CLL_REG_INPUTS, d, r);
			check(d & {8'h0, {3{d[CLL_IN_CONN_LSB +: N]}}}, in_word(sig));
		end
		summarize();
	end
endmodule
